// file: logic/video_ram_transfer_serial_port.sv
// transfer control, serial access buffer and random write capture
// assumes all pins are asynchronous; the array sits outside and
// answers a read request with row data in the same clock, while the request is high
`timescale 1ns/1ns
`include "vram_defines.svh"
module video_ram_transfer_serial_port (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic row_strobe_n_i,
    input wire logic column_strobe_n_i,
    input wire logic transfer_output_select_n_i,
    input wire logic write_n_i,
    input wire logic serial_port_enable_n_i,
    input wire logic special_function_select_i,
    input wire logic [`VRAM_ROW_W-1:0] address_i,
    input wire logic [`VRAM_DATA_W-1:0] random_dq_i,
    input wire logic serial_shift_clock_i,
    input wire logic [`VRAM_DATA_W-1:0] serial_data_pins_i,
    input wire vram_pkg::serial_access_buffer_type array_rd_data_i,
    output logic [`VRAM_DATA_W-1:0] serial_data_pins_o,
    output logic serial_data_pins_oe_o,
    output logic split_half_status_o,
    output logic random_dq_oe_o,
    output logic ram_wr_o,
    output logic [`VRAM_DATA_W-1:0] ram_data_o,
    output logic [`VRAM_DATA_W-1:0] ram_bit_en_o,
    output logic [3:0] ram_col_en_o,
    output logic [`VRAM_COL_W-1:0] ram_col_o,
    output logic ram_block_o,
    output logic [`VRAM_ROW_W-1:0] array_row_o,
    output logic array_rd_o,
    output logic array_wr_o,
    output vram_pkg::serial_access_buffer_type array_wr_data_o,
    output logic refresh_o,
    output logic write_mode_o
);
    vram_pkg::state_type q;
    vram_pkg::state_type n;
    vram_pkg::pins_type pins;
    logic ras_fall;
    logic ras_rise;
    logic cas_fall;
    logic cas_rise;
    logic sel_rise;
    logic shift_rise;
    logic [`VRAM_COL_W-1:0] col_now;

    // transfer type from the selects caught at the row strobe fall
    function automatic vram_pkg::cycle_kind_type decode_xfer(
        input logic wr_n, input logic en_n, input logic fn);
        vram_pkg::cycle_kind_type k;
        if (wr_n) begin
            k = fn ? vram_pkg::CYC_SPLIT : vram_pkg::CYC_READ;
        end else if (fn) begin
            k = vram_pkg::CYC_ALT_WRITE;
        end else if (en_n) begin
            k = vram_pkg::CYC_PSEUDO;
        end else begin
            k = vram_pkg::CYC_WRITE;
        end
        return k;
    endfunction

    assign pins = '{row_n: row_strobe_n_i, col_n: column_strobe_n_i,
        transfer_output_select_n: transfer_output_select_n_i,
        wr_n: write_n_i,
        serial_port_enable_n: serial_port_enable_n_i,
        special_function_select: special_function_select_i,
        sclk: serial_shift_clock_i, addr: address_i, dq: random_dq_i,
        serial_data_pins: serial_data_pins_i};

    assign ras_fall = q.prev.row_n & ~q.sync.row_n;
    assign ras_rise = ~q.prev.row_n & q.sync.row_n;
    assign cas_fall = q.prev.col_n & ~q.sync.col_n;
    assign cas_rise = ~q.prev.col_n & q.sync.col_n;
    assign sel_rise = ~q.prev.transfer_output_select_n &
        q.sync.transfer_output_select_n;
    assign shift_rise = ~q.prev.sclk & q.sync.sclk;
    assign col_now = cas_fall ? q.sync.addr[`VRAM_COL_W-1:0] : q.col;

    always_comb begin
        n = q;
        n.meta = pins;
        n.sync = q.meta;
        n.prev = q.sync;
        n.ram_wr = 1'b0;
        n.array_rd = 1'b0;
        n.array_wr = 1'b0;
        n.refresh = 1'b0;
        if (ras_fall) begin
            n.row = q.sync.addr;
            n.cas_seen = 1'b0;
            if (~q.sync.col_n) begin
                n.kind = vram_pkg::CYC_NONE;
            end else if (~q.sync.transfer_output_select_n) begin
                n.kind = decode_xfer(q.sync.wr_n,
                    q.sync.serial_port_enable_n,
                    q.sync.special_function_select);
                case (n.kind)
                    vram_pkg::CYC_WRITE, vram_pkg::CYC_ALT_WRITE: begin
                        n.array_wr = 1'b1;
                        n.write_mode = 1'b1;
                    end
                    vram_pkg::CYC_PSEUDO: begin
                        n.write_mode = 1'b1;
                        n.refresh = 1'b1;
                    end
                    vram_pkg::CYC_READ, vram_pkg::CYC_SPLIT: begin
                        n.write_mode = 1'b0;
                        n.refresh = 1'b1;
                    end
                    default: begin
                        n.refresh = 1'b0;
                    end
                endcase
            end else begin
                n.kind = vram_pkg::CYC_RANDOM;
                n.wr_done = 1'b0;
                n.mask_on = ~q.sync.wr_n;
                if (~q.sync.wr_n & ~q.sync.special_function_select) begin
                    n.wmask = q.sync.dq;
                end
            end
        end
        if (cas_fall & ~q.sync.row_n) begin
            if (q.kind == vram_pkg::CYC_RANDOM) begin
                n.col = q.sync.addr[`VRAM_COL_W-1:0];
                n.blk = q.sync.special_function_select;
            end else if (q.kind != vram_pkg::CYC_NONE) begin
                n.tap = q.sync.addr[`VRAM_COL_W-1:0];
                n.cas_seen = 1'b1;
                n.split_half = q.sync.addr[`VRAM_HALF_BIT];
                n.split_start = q.sync.addr[6:0];
            end
        end
        if (cas_rise) begin
            n.wr_done = 1'b0;
        end
        // capture at later of the two strobes
        if (q.kind == vram_pkg::CYC_RANDOM && !q.wr_done &&
            !q.sync.col_n && !q.sync.wr_n && !q.sync.row_n) begin
            n.ram_wr = 1'b1;
            n.wr_done = 1'b1;
            n.ram_data = q.sync.dq;
            // high bit enables line or column
            n.ram_bit_en = q.mask_on ? q.wmask : `VRAM_FULL_MASK;
            n.ram_col_en = (cas_fall ? q.sync.special_function_select :
                q.blk) ? q.sync.dq[3:0] : 4'(4'h1 << col_now[1:0]);
        end
        // full row loaded on select rise
        if (sel_rise && q.kind == vram_pkg::CYC_READ) begin
            n.array_rd = 1'b1;
            n.load_pend = 1'b1;
            n.load_split = 1'b0;
        end
        if (ras_rise) begin
            if (q.kind == vram_pkg::CYC_SPLIT && q.cas_seen) begin
                n.array_rd = 1'b1;
                n.load_pend = 1'b1;
                n.load_split = 1'b1;
            end
            if (q.kind == vram_pkg::CYC_WRITE ||
                q.kind == vram_pkg::CYC_ALT_WRITE ||
                q.kind == vram_pkg::CYC_PSEUDO) begin
                n.ptr = q.tap;
            end
            // type held to the strobe rise
            n.kind = vram_pkg::CYC_NONE;
        end
        // data moves on rising serial clock
        if (shift_rise) begin
            if (q.write_mode && !q.sync.serial_port_enable_n &&
                q.kind != vram_pkg::CYC_ALT_WRITE) begin
                n.serial_access_buffer[q.ptr] = q.sync.serial_data_pins;
            end
            if (!q.write_mode) begin
                n.sout = q.serial_access_buffer[q.ptr];
            end
            if (q.split_pend && q.ptr[6:0] == `VRAM_HALF_END &&
                q.ptr[`VRAM_HALF_BIT] != q.split_half) begin
                n.ptr = {q.split_half, q.split_start};
                n.split_pend = 1'b0;
            end else begin
                n.ptr = 8'(q.ptr + 8'h01);
            end
        end
        if (q.load_pend) begin
            n.load_pend = 1'b0;
            if (q.load_split) begin
                for (int i = 0; i < `VRAM_SAM_DEPTH / 2; i++) begin
                    n.serial_access_buffer[{q.split_half, 7'(i)}] =
                        array_rd_data_i[{q.split_half, 7'(i)}];
                end
                n.split_pend = 1'b1;
            end else begin
                n.serial_access_buffer = array_rd_data_i;
                n.ptr = q.tap;
                n.split_pend = 1'b0;
            end
        end
        // enable gates serial output; alt disables
        n.sout_oe = ~n.write_mode & ~q.sync.serial_port_enable_n &
            (n.kind != vram_pkg::CYC_ALT_WRITE);
        n.half_status = n.ptr[`VRAM_HALF_BIT];
        // random outputs never on during transfers
        n.dq_oe = (n.kind == vram_pkg::CYC_RANDOM) & ~q.sync.col_n &
            ~q.sync.transfer_output_select_n & q.sync.wr_n;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q <= '0;
            // strobes idle high so no false edge follows reset
            q.meta.row_n <= 1'b1;
            q.meta.col_n <= 1'b1;
            q.meta.transfer_output_select_n <= 1'b1;
            q.meta.wr_n <= 1'b1;
            q.meta.serial_port_enable_n <= 1'b1;
            q.sync.row_n <= 1'b1;
            q.sync.col_n <= 1'b1;
            q.sync.transfer_output_select_n <= 1'b1;
            q.sync.wr_n <= 1'b1;
            q.sync.serial_port_enable_n <= 1'b1;
            q.prev.row_n <= 1'b1;
            q.prev.col_n <= 1'b1;
            q.prev.transfer_output_select_n <= 1'b1;
            q.prev.wr_n <= 1'b1;
            q.prev.serial_port_enable_n <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign serial_data_pins_o = q.sout;
    assign serial_data_pins_oe_o = q.sout_oe;
    assign split_half_status_o = q.half_status;
    assign random_dq_oe_o = q.dq_oe;
    assign ram_wr_o = q.ram_wr;
    assign ram_data_o = q.ram_data;
    assign ram_bit_en_o = q.ram_bit_en;
    assign ram_col_en_o = q.ram_col_en;
    assign ram_col_o = q.col;
    assign ram_block_o = q.blk;
    assign array_row_o = q.row;
    assign array_rd_o = q.array_rd;
    assign array_wr_o = q.array_wr;
    assign array_wr_data_o = q.serial_access_buffer;
    assign refresh_o = q.refresh;
    assign write_mode_o = q.write_mode;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    chk_write_xfer: assert property (
        ras_fall && q.sync.col_n && !q.sync.transfer_output_select_n &&
        !q.sync.wr_n && !q.sync.serial_port_enable_n &&
        !q.sync.special_function_select |=> array_wr_o && write_mode_o)
        else $error("write transfer not performed");
    chk_pseudo_nomove: assert property (
        ras_fall && q.sync.col_n && !q.sync.transfer_output_select_n &&
        !q.sync.wr_n && q.sync.serial_port_enable_n &&
        !q.sync.special_function_select
        |=> !array_wr_o && write_mode_o && refresh_o)
        else $error("pseudo write moved data or kept read mode");
    chk_read_refresh: assert property (
        ras_fall && q.sync.col_n && !q.sync.transfer_output_select_n &&
        q.sync.wr_n |=> refresh_o && !write_mode_o)
        else $error("read transfer without refresh or read mode");
    chk_kind_held: assert property (
        !q.sync.row_n && !q.prev.row_n && !q.load_pend
        |=> q.kind == $past(q.kind))
        else $error("transfer type changed while row strobe low");
    chk_ptr_wrap: assert property (
        shift_rise && !q.load_pend && !q.split_pend && !ras_rise
        |=> q.ptr == 8'($past(q.ptr) + 8'h01))
        else $error("serial pointer did not step by one");
    chk_old_bit: assert property (
        array_rd_o && !shift_rise |=> $stable(serial_data_pins_o))
        else $error("serial output changed before serial clock");
    chk_sdq_enable: assert property (
        serial_data_pins_oe_o |-> !write_mode_o &&
        !q.prev.serial_port_enable_n)
        else $error("serial output on in write mode or disabled");
    chk_alt_disable: assert property (
        q.kind == vram_pkg::CYC_ALT_WRITE |-> !serial_data_pins_oe_o)
        else $error("serial port on during alternate write");
    chk_qsf_half: assert property (
        split_half_status_o == q.ptr[`VRAM_HALF_BIT])
        else $error("half status disagrees with pointer");
    chk_dq_hiz: assert property (
        q.kind != vram_pkg::CYC_RANDOM |-> !random_dq_oe_o)
        else $error("random outputs on outside random cycle");
    chk_wr_capture: assert property (
        ram_wr_o |-> !$past(q.sync.col_n) && !$past(q.sync.wr_n))
        else $error("write captured before both strobes low");
    chk_alt_write: assert property (
        ras_fall && q.sync.col_n && !q.sync.transfer_output_select_n &&
        !q.sync.wr_n && q.sync.special_function_select
        |=> array_wr_o && write_mode_o)
        else $error("alternate write transfer not performed");
    chk_split_kind: assert property (
        ras_fall && q.sync.col_n && !q.sync.transfer_output_select_n &&
        q.sync.wr_n && q.sync.special_function_select
        |=> q.kind == vram_pkg::CYC_SPLIT)
        else $error("split read transfer not selected");
    chk_row_latch: assert property (
        ras_fall |=> array_row_o == $past(q.sync.addr))
        else $error("row address not latched at row strobe");
    chk_tap_load: assert property (
        cas_fall && !q.sync.row_n && q.kind == vram_pkg::CYC_PSEUDO
        |=> q.tap == $past(q.sync.addr[`VRAM_COL_W-1:0]))
        else $error("tap not taken at column strobe");
    chk_serial_in: assert property (
        shift_rise && q.write_mode && !q.sync.serial_port_enable_n &&
        q.kind != vram_pkg::CYC_ALT_WRITE && !q.load_pend
        |=> q.serial_access_buffer[$past(q.ptr)] ==
        $past(q.sync.serial_data_pins))
        else $error("serial input not stored");
    chk_mask_off: assert property (
        ram_wr_o && !$past(q.mask_on) |-> ram_bit_en_o == `VRAM_FULL_MASK)
        else $error("unmasked write lost a data line");
    chk_ptr_ungated: assert property (
        shift_rise && q.sync.serial_port_enable_n && !q.load_pend &&
        !q.split_pend && !ras_rise |=> q.ptr == 8'($past(q.ptr) + 8'h01))
        else $error("pointer held while serial port disabled");
    chk_input_mode: assert property (
        write_mode_o |-> !serial_data_pins_oe_o)
        else $error("serial output on in input mode");

    cov_read_xfer: cover property (
        q.kind == vram_pkg::CYC_READ ##[1:200] array_rd_o);
    cov_split_load: cover property (q.load_pend && q.load_split);
    cov_pseudo: cover property (q.kind == vram_pkg::CYC_PSEUDO);
    cov_wrap: cover property (shift_rise && q.ptr == 8'hFF);
    cov_split_switch: cover property (shift_rise && q.split_pend &&
        q.ptr[6:0] == `VRAM_HALF_END);
endmodule

// file: common/vram_defines.svh
// constants of the transfer and serial port of the video memory
// assumes pins are sampled by a single 50 MHz system clock
// Contract
// - random write data taken at later strobe
// - high mask bit enables column or line
// - transfer write or pseudo write chosen
// - transfer writes switch serial port to input
// - read and pseudo transfers refresh row
// - transfer select low chooses transfer type
// - old serial bit held until clock
// - read transfer ignores enable, sets read mode
// - alternate write keeps serial port disabled
// - column strobe in pseudo write sets tap
// - nine row bits latched at row strobe
// - split read reloads half chosen by A7
// - serial data moves on rising clock
// - serial pointer counts up modulo 256
// - serial enable low enables serial pins
// - serial clock advances pointer despite enable
// - half status shows pointer half
// - random outputs off during transfer cycles
`ifndef VRAM_DEFINES_SVH
`define VRAM_DEFINES_SVH
`define VRAM_ROW_W 9
`define VRAM_COL_W 8
`define VRAM_DATA_W 8
`define VRAM_SAM_DEPTH 256
`define VRAM_HALF_BIT 7
`define VRAM_HALF_END 7'h7F
`define VRAM_FULL_MASK 8'hFF
`define VRAM_RST_WRITE_MODE 1'b0
`endif

// file: common/vram_pkg.sv
// types shared by the transfer and serial port logic
// assumes the defines header is on the include path
`include "vram_defines.svh"
package vram_pkg;
    typedef enum logic [2:0] {
        CYC_NONE = 3'b000,
        CYC_WRITE = 3'b001,
        CYC_ALT_WRITE = 3'b010,
        CYC_PSEUDO = 3'b011,
        CYC_READ = 3'b100,
        CYC_SPLIT = 3'b101,
        CYC_RANDOM = 3'b110
    } cycle_kind_type;

    typedef logic [`VRAM_SAM_DEPTH-1:0][`VRAM_DATA_W-1:0]
        serial_access_buffer_type;

    typedef struct packed {
        logic row_n;
        logic col_n;
        logic transfer_output_select_n;
        logic wr_n;
        logic serial_port_enable_n;
        logic special_function_select;
        logic sclk;
        logic [`VRAM_ROW_W-1:0] addr;
        logic [`VRAM_DATA_W-1:0] dq;
        logic [`VRAM_DATA_W-1:0] serial_data_pins;
    } pins_type;

    typedef struct packed {
        pins_type meta;
        pins_type sync;
        pins_type prev;
        cycle_kind_type kind;
        logic [`VRAM_ROW_W-1:0] row;
        logic cas_seen;
        logic wr_done;
        logic mask_on;
        logic [`VRAM_DATA_W-1:0] wmask;
        logic [`VRAM_COL_W-1:0] col;
        logic blk;
        logic [`VRAM_COL_W-1:0] tap;
        logic write_mode;
        logic [6:0] split_start;
        logic split_half;
        logic split_pend;
        logic load_pend;
        logic load_split;
        serial_access_buffer_type serial_access_buffer;
        logic [`VRAM_COL_W-1:0] ptr;
        logic [`VRAM_DATA_W-1:0] sout;
        logic sout_oe;
        logic half_status;
        logic ram_wr;
        logic [`VRAM_DATA_W-1:0] ram_data;
        logic [`VRAM_DATA_W-1:0] ram_bit_en;
        logic [3:0] ram_col_en;
        logic array_rd;
        logic array_wr;
        logic refresh;
        logic dq_oe;
    } state_type;
endpackage

// file: verification/array_row_model.sv
// array model that answers row reads of the transfer port
// assumes read data is sampled one clock after the request rises
`timescale 1ns/1ns
`include "vram_defines.svh"
module array_row_model (
    input wire logic rd_i,
    input wire logic [`VRAM_ROW_W-1:0] row_i,
    output vram_pkg::serial_access_buffer_type data_o
);
    // row pattern, inverted outside a request so stale data shows
    always_comb begin
        for (int i = 0; i < `VRAM_SAM_DEPTH; i++) begin
            data_o[i] = 8'(i) ^ row_i[7:0] ^ {8{!rd_i}};
        end
    end
endmodule

// file: verification/video_ram_transfer_serial_port_test.sv
// self-checking bench of the transfer and serial port
// assumes the array model answers reads; bench plays the controller
`timescale 1ns/1ns
`include "vram_defines.svh"
module video_ram_transfer_serial_port_test;
    logic clk_i = 0, nrst_i = 0, row_n = 1, col_n = 1, sel_n = 1;
    logic wr_n = 1, serial_port_enable_n = 1, sclk = 0, in_xfer = 0;
    logic special_function_select = 0;
    logic [8:0] addr = '0, row;
    logic [7:0] dq = '0, sdi = '0, sdo, ram_data, bit_en, ram_col;
    logic sdo_oe, half, dq_oe, ram_wr, blk, rd, wr, refr, wmode;
    logic [3:0] col_en;
    vram_pkg::serial_access_buffer_type rd_data, wr_data;
    int fails = 0, cmp_count = 0, cycles = 0;
    int n_ref = 0, n_wr = 0, n_rd = 0, n_ram = 0;

    video_ram_transfer_serial_port dut_u (.clk_i(clk_i), .nrst_i(nrst_i),
        .row_strobe_n_i(row_n), .column_strobe_n_i(col_n),
        .transfer_output_select_n_i(sel_n), .write_n_i(wr_n),
        .serial_port_enable_n_i(serial_port_enable_n),
        .special_function_select_i(special_function_select),
        .address_i(addr), .random_dq_i(dq), .serial_shift_clock_i(sclk),
        .serial_data_pins_i(sdi), .array_rd_data_i(rd_data),
        .serial_data_pins_o(sdo), .serial_data_pins_oe_o(sdo_oe),
        .split_half_status_o(half), .random_dq_oe_o(dq_oe),
        .ram_wr_o(ram_wr), .ram_data_o(ram_data), .ram_bit_en_o(bit_en),
        .ram_col_en_o(col_en), .ram_col_o(ram_col), .ram_block_o(blk),
        .array_row_o(row), .array_rd_o(rd), .array_wr_o(wr),
        .array_wr_data_o(wr_data), .refresh_o(refr), .write_mode_o(wmode));

    array_row_model model_u (.rd_i(rd), .row_i(row), .data_o(rd_data));

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    task automatic check(input string name, input logic [8:0] exp,
                         input logic [8:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // pulse counters and timeout
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (refr === 1'b1) n_ref <= n_ref + 1;
        if (wr === 1'b1) n_wr <= n_wr + 1;
        if (rd === 1'b1) n_rd <= n_rd + 1;
        if (ram_wr === 1'b1) n_ram <= n_ram + 1;
        if (in_xfer) check("random_oe", 0, dq_oe);
        if (cycles == 20000) begin
            fails++;
            final_report();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic set(input logic r, c, s, w, e, f, input logic [8:0] a);
        @(posedge clk_i);
        row_n <= r;
        col_n <= c;
        sel_n <= s;
        wr_n <= w;
        serial_port_enable_n <= e;
        special_function_select <= f;
        addr <= a;
        step(5);
    endtask

    // one serial clock of 160 ns
    task automatic pulse();
        @(posedge clk_i) sclk <= 1'b1;
        step(3);
        @(posedge clk_i) sclk <= 1'b0;
        step(3);
    endtask

    task automatic rd_xfer(input logic [8:0] r, input logic [7:0] t,
                           input logic f);
        int n0, d0;
        logic [7:0] old;
        n0 = n_ref;
        d0 = n_rd;
        in_xfer = 1;
        set(1, 1, 0, 1, 0, f, r);
        set(0, 1, 0, 1, 0, f, r);
        set(0, 1, 0, 0, 1, f, r);
        set(0, 0, 0, 1, 0, f, {1'b0, t});
        check("write_mode", 0, wmode);
        check("refresh", 9'(n0 + 1), 9'(n_ref));
        check("row", r, 9'(row));
        old = sdo;
        set(0, 0, 1, 1, 0, f, 0);
        check("held_bit", old, sdo);
        set(1, 1, 1, 1, 0, 0, 0);
        check("array_rd", 9'(d0 + 1), 9'(n_rd));
        in_xfer = 0;
    endtask

    task automatic wr_xfer();
        int w0, r0;
        w0 = n_wr;
        r0 = n_ref;
        in_xfer = 1;
        set(1, 1, 0, 0, 1, 0, 9'h055);
        set(0, 1, 0, 0, 1, 0, 9'h055);
        set(0, 0, 0, 0, 0, 0, 9'h010);
        check("write_mode", 1, wmode);
        check("serial_oe", 0, sdo_oe);
        check("pseudo_ref", 9'(r0 + 1), 9'(n_ref));
        check("pseudo_move", 9'(w0), 9'(n_wr));
        set(1, 1, 1, 1, 0, 0, 0);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_i) sdi <= 8'h30 + 8'(i);
            pulse();
        end
        set(1, 1, 0, 0, 0, 0, 9'h077);
        set(0, 1, 0, 0, 0, 0, 9'h077);
        set(1, 1, 1, 1, 0, 0, 0);
        check("xfer_write", 9'(w0 + 1), 9'(n_wr));
        for (int i = 0; i < 3; i++) begin
            check("written", 9'(8'h30 + i), 9'(wr_data[16 + i]));
        end
        set(1, 1, 0, 0, 1, 1, 9'h078);
        set(0, 1, 0, 0, 1, 1, 9'h078);
        check("alt_oe", 0, sdo_oe);
        set(1, 1, 1, 1, 1, 0, 0);
        check("alt_write", 9'(w0 + 2), 9'(n_wr));
        in_xfer = 0;
    endtask

    task automatic rand_wr();
        int m0;
        m0 = n_ram;
        @(posedge clk_i) dq <= 8'h5A;
        set(1, 1, 1, 0, 1, 0, 9'h012);
        set(0, 1, 1, 0, 1, 0, 9'h012);
        set(0, 1, 1, 1, 1, 0, 9'h012);
        @(posedge clk_i) dq <= 8'hC3;
        set(0, 0, 1, 1, 1, 0, 9'h034);
        check("early_take", 9'(m0), 9'(n_ram));
        @(posedge clk_i) dq <= 8'h3C;
        set(0, 0, 1, 0, 1, 0, 9'h034);
        check("ram_wr", 9'(m0 + 1), 9'(n_ram));
        check("ram_data", 8'h3C, ram_data);
        check("bit_en", 8'h5A, bit_en);
        check("ram_col", 8'h34, ram_col);
        check("col_en", 9'h001, 9'(col_en));
        check("block", 0, 9'(blk));
        set(1, 1, 1, 1, 1, 0, 0);
    endtask

    initial begin
        step(8);
        nrst_i <= 1'b1;
        step(4);
        for (int i = 0; i < 8; i++) begin
            set(0, 1, 1, 1, 1, 0, 9'(i));
            set(1, 1, 1, 1, 1, 0, 0);
        end
        rd_xfer(9'h1A3, 8'hFE, 0);
        for (int i = 0; i < 3; i++) begin
            pulse();
            check("serial_out", 9'(8'(8'hFE + i) ^ 8'hA3), sdo);
            check("half", 9'(i == 0), half);
        end
        check("serial_oe", 1, sdo_oe);
        set(1, 1, 1, 1, 1, 0, 0);
        pulse();
        pulse();
        check("serial_off", 0, sdo_oe);
        set(1, 1, 1, 1, 0, 0, 0);
        pulse();
        check("ungated", 8'h03 ^ 8'hA3, sdo);
        wr_xfer();
        rd_xfer(9'h0F0, 8'h20, 0);
        pulse();
        check("read_again", 8'h20 ^ 8'hF0, sdo);
        rd_xfer(9'h0C3, 8'h85, 1);
        repeat (95) pulse();
        check("old_half", 8'h7F ^ 8'hF0, sdo);
        pulse();
        check("split_start", 8'h85 ^ 8'hC3, sdo);
        check("split_half", 1, half);
        rand_wr();
        final_report();
    end
endmodule
